// ===== hw/sbcspi_defines.vh
`ifndef SBCSPI_DEFINES_VH
`define SBCSPI_DEFINES_VH

// frame geometry
`define SBCSPI_WORD_BITS 16
`define SBCSPI_CNT_BITS 4
`define SBCSPI_CNT_ZERO 4'h0
`define SBCSPI_CNT_ONE 4'h1
`define SBCSPI_RO_LOAD_CNT 4'h7

// input word fields
`define SBCSPI_IN_WD_BIT 15
`define SBCSPI_IN_MODE_HI 14
`define SBCSPI_IN_MODE_LO 12
`define SBCSPI_IN_SEL_HI 11
`define SBCSPI_IN_SEL_LO 9
`define SBCSPI_DATA_HI 8
`define SBCSPI_DATA_BITS 9

// the mode and select fields as they sit in the shift register after seven bits
`define SBCSPI_EARLY_MODE_HI 5
`define SBCSPI_EARLY_MODE_LO 3
`define SBCSPI_EARLY_SEL_HI 2
`define SBCSPI_EARLY_SEL_LO 0
// read-back data field in the output register after seven shifts
`define SBCSPI_RO_OUT_HI 15
`define SBCSPI_RO_OUT_LO 7

// mode codes
`define SBCSPI_MODE_INVALID 3'h0
`define SBCSPI_MODE_RESTART 3'h1
`define SBCSPI_MODE_FLASH 3'h2
`define SBCSPI_MODE_NORMAL 3'h3
`define SBCSPI_MODE_SLEEP 3'h4
`define SBCSPI_MODE_STOP 3'h5
`define SBCSPI_MODE_FAILSAFE 3'h6
`define SBCSPI_MODE_READONLY 3'h7

// reset values
`define SBCSPI_WORD_RESET 16'h0000
`define SBCSPI_SEL_RESET 3'h0

// read-back registers on the flat status bus
`define SBCSPI_NUM_REGS 8

// fifo
`define SBCSPI_FIFO_DEPTH 32
`define SBCSPI_FIFO_AW 5

`endif

// ===== hw/sbcspi_frame_interface.v
// What this block does
// RULE_01 - receive 16-bit control words on serial input, return 16-bit word on serial output
// RULE_02 - a frame starts when the master pulls chip select low
// RULE_03 - on chip select rising, a valid received word becomes the new control word
// RULE_04 - serial output released to high impedance while chip select is high
// RULE_05 - input bit sampled on every falling serial clock edge
// RULE_06 - output register advances after every rising serial clock edge
// RULE_07 - clock edges counted modulo 16; word discarded on mismatch
// RULE_08 - after a miscounted frame, error flag is first output bit of next frame
// RULE_09 - no daisy chain; input bits never reach the serial output
// RULE_10 - mode code 000 makes the whole word ignored as wrong command
// RULE_11 - mode transitions forbidden by the mode machine are ignored
// RULE_12 - any wrong command sets the fail flag and interrupts unless inhibited
// RULE_13 - after a corrupted frame the previous output word is repeated
// RULE_14 - mode 111 reads back selected register in same frame, writes nothing
// RULE_15 - master supplies a correct watchdog refresh bit even in read-only frames; this block never checks that bit
// RULE_16 - three-bit select field picks one of eight registers to write or read
// RULE_17 - words shift most significant bit first in both directions
// RULE_18 - clock edges ignored while deselected; bit counter restarts at each selection
`timescale 1ns/10ps
`include "sbcspi_defines.vh"

module sbcspi_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // raw pin and its synchronised copy
  input wire pinIn,
  output reg syncOut
);
  reg meta;

  always @(posedge clk) begin
    if (rst) begin
      meta <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta <= pinIn;
      syncOut <= meta;
    end
  end
endmodule

module sbcspi_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] fill;
  reg outHeld;
  wire push;
  wire pop;
  wire memHasWord;
  wire loadOut;
  wire [AW:0] occupancy;

  assign memHasWord = (fill != {(AW+1){1'b0}});
  // the output register counts toward the depth
  assign occupancy = fill + {{AW{1'b0}}, outHeld};
  assign inReady = (occupancy != DEPTH[AW:0]);
  assign outValid = outHeld;
  assign loadOut = memHasWord && (!outHeld || outReady);
  assign push = inValid && inReady;
  assign pop = loadOut;

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
      outHeld <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
        outData <= mem[rdPtr];
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
      if (loadOut) begin
        outHeld <= 1'b1;
      end else if (outReady) begin
        outHeld <= 1'b0;
      end
    end
  end
endmodule

module sbcspi_frame_interface (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial link pins
  input wire chipSelectN,
  input wire serialClock,
  input wire serialDataIn,
  output wire serialDataOut,
  output wire serialDataOutOe,
  // status from the rest of the chip
  input wire [71:0] cfgReadData,
  input wire swDevMode,
  input wire irqInhibit,
  input wire spiFailClear,
  // control word stream to the rest of the chip
  output wire ctrlValid,
  input wire ctrlReady,
  output wire [15:0] ctrlData,
  // state outputs
  output reg [2:0] modeState,
  output reg [15:0] controlWord,
  output reg spiFail,
  output reg irqPulse
);
  // two-stage synchronisers, then a third stage for edge finding
  wire csSync;
  wire clkSync;
  wire dinSync;
  reg csPrev;
  reg clkPrev;

  reg [15:0] inShift;
  reg [15:0] outShift;
  reg [15:0] lastOutWord;
  reg [3:0] bitCount;
  reg anyEdge;
  reg countError;
  reg repeatLast;
  reg roFrame;
  reg [2:0] lastSel;

  wire selStart;
  wire selEnd;
  wire sclkFall;
  wire sclkRise;
  wire [2:0] rxMode;
  wire [2:0] rxSel;
  wire [2:0] earlyMode;
  wire [2:0] earlySel;
  wire countOk;
  wire modeOk;
  wire pushReady;
  wire frameGood;
  wire [15:0] freshWord;
  wire roLoad;
  reg transOk;
  reg [8:0] readSel;
  reg [8:0] readEarly;
  integer i;

  sbcspi_sync2 #(
    .RESET_VAL(1'b1)
  ) csSyncer (
    .clk(clk),
    .rst(rst),
    .pinIn(chipSelectN),
    .syncOut(csSync)
  );

  sbcspi_sync2 #(
    .RESET_VAL(1'b0)
  ) clkSyncer (
    .clk(clk),
    .rst(rst),
    .pinIn(serialClock),
    .syncOut(clkSync)
  );

  sbcspi_sync2 #(
    .RESET_VAL(1'b0)
  ) dinSyncer (
    .clk(clk),
    .rst(rst),
    .pinIn(serialDataIn),
    .syncOut(dinSync)
  );

  // previous synchronised levels for edge finding, reset to the idle pin levels
  always @(posedge clk) begin
    if (rst) begin
      csPrev <= 1'b1;
      clkPrev <= 1'b0;
    end else begin
      csPrev <= csSync;
      clkPrev <= clkSync;
    end
  end

  assign selStart = csPrev && !csSync; // [RULE_02]
  assign selEnd = !csPrev && csSync;
  // edges count only while selected [RULE_18]
  assign sclkFall = !csSync && !csPrev && clkPrev && !clkSync;
  assign sclkRise = !csSync && !csPrev && !clkPrev && clkSync;

  assign rxMode = inShift[`SBCSPI_IN_MODE_HI:`SBCSPI_IN_MODE_LO];
  assign rxSel = inShift[`SBCSPI_IN_SEL_HI:`SBCSPI_IN_SEL_LO]; // [RULE_16]
  assign earlyMode = inShift[`SBCSPI_EARLY_MODE_HI:`SBCSPI_EARLY_MODE_LO];
  assign earlySel = inShift[`SBCSPI_EARLY_SEL_HI:`SBCSPI_EARLY_SEL_LO];

  // register read-back muxes over the flat status bus
  always @* begin
    readSel = {`SBCSPI_DATA_BITS{1'b0}};
    readEarly = {`SBCSPI_DATA_BITS{1'b0}};
    for (i = 0; i < `SBCSPI_NUM_REGS; i = i + 1) begin
      if (lastSel == i[2:0]) begin
        readSel = cfgReadData[i*`SBCSPI_DATA_BITS +: `SBCSPI_DATA_BITS];
      end
      if (earlySel == i[2:0]) begin
        readEarly = cfgReadData[i*`SBCSPI_DATA_BITS +: `SBCSPI_DATA_BITS]; // [RULE_16]
      end
    end
  end

  // mode machine transition check
  always @* begin
    case (rxMode)
      `SBCSPI_MODE_INVALID: transOk = 1'b0; // [RULE_10]
      `SBCSPI_MODE_RESTART: transOk = (modeState == `SBCSPI_MODE_FLASH); // [RULE_11]
      `SBCSPI_MODE_FLASH: transOk = (modeState == `SBCSPI_MODE_NORMAL) ||
                                    (modeState == `SBCSPI_MODE_FLASH); // [RULE_11]
      `SBCSPI_MODE_NORMAL: transOk = 1'b1;
      `SBCSPI_MODE_SLEEP: transOk = (modeState != `SBCSPI_MODE_FLASH);
      `SBCSPI_MODE_STOP: transOk = (modeState != `SBCSPI_MODE_FLASH);
      `SBCSPI_MODE_FAILSAFE: transOk = swDevMode; // [RULE_11]
      `SBCSPI_MODE_READONLY: transOk = 1'b1;
      default: transOk = 1'b0;
    endcase
  end

  // a full fifo refuses the word like any other wrong command
  assign countOk = anyEdge && (bitCount == `SBCSPI_CNT_ZERO); // [RULE_07]
  assign modeOk = transOk;
  assign frameGood = countOk && modeOk && (roFrame || pushReady);
  // response: current mode, last selected register and its contents
  assign freshWord = {1'b0, modeState, lastSel, readSel};
  // read-only request seen once seven bits are in, between serial clock edges
  assign roLoad = !sclkFall && !sclkRise && anyEdge && !roFrame &&
                  (bitCount == `SBCSPI_RO_LOAD_CNT) && (earlyMode == `SBCSPI_MODE_READONLY);

  sbcspi_fifo #(
    .WIDTH(`SBCSPI_WORD_BITS),
    .DEPTH(`SBCSPI_FIFO_DEPTH),
    .AW(`SBCSPI_FIFO_AW)
  ) ctrlFifo (
    .clk(clk),
    .rst(rst),
    .inValid(selEnd && countOk && modeOk && !roFrame),
    .inReady(pushReady),
    .inData(inShift),
    .outValid(ctrlValid),
    .outReady(ctrlReady),
    .outData(ctrlData)
  );

  // serial shifting and frame bookkeeping
  always @(posedge clk) begin
    if (rst) begin
      inShift <= `SBCSPI_WORD_RESET;
      outShift <= `SBCSPI_WORD_RESET;
      lastOutWord <= `SBCSPI_WORD_RESET;
      bitCount <= `SBCSPI_CNT_ZERO;
      anyEdge <= 1'b0;
      roFrame <= 1'b0;
    end else begin
      if (selStart) begin
        bitCount <= `SBCSPI_CNT_ZERO; // [RULE_18]
        anyEdge <= 1'b0;
        roFrame <= 1'b0;
        if (repeatLast) begin
          // old word again, flag first when the count was bad [RULE_13] [RULE_08]
          outShift <= {countError, lastOutWord[`SBCSPI_WORD_BITS-2:0]};
        end else begin
          outShift <= freshWord;
          lastOutWord <= freshWord;
        end
      end else begin
        if (sclkFall) begin
          inShift <= {inShift[`SBCSPI_WORD_BITS-2:0], dinSync}; // [RULE_05] [RULE_17]
          bitCount <= bitCount + `SBCSPI_CNT_ONE; // [RULE_07]
          anyEdge <= 1'b1;
        end
        if (sclkRise) begin
          // zeros fill behind, input never forwarded [RULE_06] [RULE_09] [RULE_17]
          outShift <= {outShift[`SBCSPI_WORD_BITS-2:0], 1'b0};
        end
        if (roLoad) begin
          // seven bits already out, so the data field now sits at the top [RULE_14]
          roFrame <= 1'b1;
          outShift[`SBCSPI_RO_OUT_HI:`SBCSPI_RO_OUT_LO] <= readEarly;
        end
      end
    end
  end

  // frame end: adopt the word, steer mode, report wrong commands
  always @(posedge clk) begin
    if (rst) begin
      modeState <= `SBCSPI_MODE_NORMAL;
      controlWord <= `SBCSPI_WORD_RESET;
      spiFail <= 1'b0;
      irqPulse <= 1'b0;
      countError <= 1'b0;
      repeatLast <= 1'b0;
      lastSel <= `SBCSPI_SEL_RESET;
    end else begin
      irqPulse <= 1'b0;
      if (selEnd) begin
        countError <= !countOk; // [RULE_08]
        repeatLast <= !frameGood; // [RULE_13]
        if (frameGood) begin
          lastSel <= rxSel; // [RULE_16]
          if (!roFrame) begin
            controlWord <= inShift; // [RULE_03] [RULE_01]
            modeState <= rxMode;
          end
        end else begin
          spiFail <= 1'b1; // [RULE_12]
          irqPulse <= !irqInhibit; // [RULE_12]
        end
      end else if (spiFailClear) begin
        spiFail <= 1'b0;
      end
    end
  end

  assign serialDataOut = outShift[`SBCSPI_WORD_BITS-1]; // [RULE_01]
  assign serialDataOutOe = !csSync; // [RULE_04]
endmodule

// ===== tb/sbcspi_props.sv
`timescale 1ns/10ps
module sbcspi_props (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire chipSelectN,
  input wire serialDataOutOe,
  input wire irqInhibit,
  input wire spiFailClear,
  input wire ctrlValid,
  input wire ctrlReady,
  input wire [15:0] ctrlData,
  input wire [15:0] controlWord,
  input wire spiFail,
  input wire irqPulse
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_oe_on: assert property ($fell(chipSelectN) |-> ##[1:6] serialDataOutOe)
    else $error("oe late");
  chk_oe_off: assert property ($rose(chipSelectN) |-> ##[1:6] !serialDataOutOe)
    else $error("oe stuck");
  chk_cw_hold: assert property (!chipSelectN [*6] |-> $stable(controlWord))
    else $error("word moved");
  chk_irq_fail: assert property (irqPulse |-> spiFail)
    else $error("irq without fail");
  chk_irq_one: assert property (irqPulse |=> !irqPulse)
    else $error("irq long");
  chk_irq_mask: assert property (irqInhibit [*3] |-> !irqPulse)
    else $error("irq masked");
  chk_fail_hold: assert property (spiFail && !spiFailClear |=> spiFail)
    else $error("fail lost");
  chk_q_hold: assert property (ctrlValid && !ctrlReady |=> ctrlValid && $stable(ctrlData))
    else $error("queue moved");
  cover property (irqPulse);
  cover property (ctrlValid && !ctrlReady);
  cover property ($fell(chipSelectN));
endmodule
bind sbcspi_frame_interface sbcspi_props u_chk (.*);

// ===== tb/sbcspi_master.sv
`timescale 1ns/10ps
module sbcspi_master (
  // link pins
  output reg chip_select_n,
  output reg sck,
  output reg mosi,
  input wire miso
);
  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // n clocks, msb first; rx keeps the last 16 bits sampled
  task xfer(input [15:0] w, input integer n, output [15:0] rx);
    integer i;
    begin
      rx = 16'h0000;
      chip_select_n = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        #80 rx = {rx[14:0], miso};
        sck = 1'b1;
        // data changes on the rise so it stands still at the capturing fall
        mosi = w[15 - i % 16];
        #80 sck = 1'b0;
      end
      #80 chip_select_n = 1'b1;
      mosi = ~mosi;
      #100;
    end
  endtask
endmodule

// ===== tb/tb_sbcspi_frame_interface.sv
`timescale 1ns/10ps
module tb_sbcspi_frame_interface;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg irqInhibit = 1'b0;
  reg spiFailClear = 1'b0;
  reg ctrlReady = 1'b1;
  reg swDevMode = 1'b0;
  wire chip_select_n, sck, mosi, serial_data_out, oe, ctrlValid, spiFail, irqPulse;
  wire [15:0] ctrlData, cw;
  wire [2:0] modeState;
  wire [71:0] cfg = 72'h0123_4567_89AB_CDEF_5A;
  wire miso = oe ? serial_data_out : 1'bz;
  integer err_count = 0;
  integer n_checks = 0;
  integer irqSeen = 0;
  integer i;
  reg [15:0] rx, last;
  always #5 clk = ~clk;
  // interrupt pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (irqPulse === 1'b1)
      irqSeen <= irqSeen + 1;
  end
  sbcspi_frame_interface u_dut (
    .clk(clk), .rst(rst), .chipSelectN(chip_select_n), .serialClock(sck), .serialDataIn(mosi),
    .serialDataOut(serial_data_out), .serialDataOutOe(oe), .cfgReadData(cfg), .swDevMode(swDevMode),
    .irqInhibit(irqInhibit), .spiFailClear(spiFailClear), .ctrlValid(ctrlValid),
    .ctrlReady(ctrlReady), .ctrlData(ctrlData), .modeState(modeState), .controlWord(cw),
    .spiFail(spiFail), .irqPulse(irqPulse));
  sbcspi_master u_mst (.chip_select_n(chip_select_n), .sck(sck), .mosi(mosi), .miso(miso));
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  function [15:0] rsp(input [2:0] m, input [2:0] s);
    rsp = {1'b0, m, s, cfg[s * 9 +: 9]};
  endfunction
  task snd(input [15:0] w, input integer n);
    begin
      last = rx;
      @(negedge clk);
      u_mst.xfer(w, n, rx);
    end
  endtask
  task clr;
    begin
      @(negedge clk) spiFailClear = 1'b1;
      @(negedge clk) spiFailClear = 1'b0;
      chk(spiFail, 1'b0);
    end
  endtask
  task t_write;
    begin
      snd(16'hB655, 16);
      chk(rx, rsp(3'h3, 3'h0));
      chk(cw, 16'hB655);
      $display("write done");
    end
  endtask
  task t_count;
    begin
      snd(16'h5A00, 15);
      chk(spiFail, 1'b1);
      chk(irqSeen[15:0], 16'h0001);
      chk(cw, 16'hB655);
      snd(16'hB411, 16);
      chk(rx, rsp(3'h3, 3'h3) | 16'h8000);
      chk(cw, 16'hB411);
      clr;
      $display("count done");
    end
  endtask
  task t_bad;
    begin
      @(negedge clk) irqInhibit = 1'b1;
      snd(16'h89FF, 16);
      chk(rx, rsp(3'h3, 3'h2));
      chk(cw, 16'hB411);
      chk(spiFail, 1'b1);
      clr;
      snd(16'h5C00, 16);
      chk(rx, last);
      chk(modeState, 3'h5);
      snd(16'hA000, 16);
      chk(rx, rsp(3'h5, 3'h6));
      chk(modeState, 3'h5);
      chk(spiFail, 1'b1);
      clr;
      snd(16'h3600, 16);
      chk(rx, last);
      chk(modeState, 3'h3);
      chk(irqSeen[15:0], 16'h0001);
      @(negedge clk) irqInhibit = 1'b0;
      $display("bad done");
    end
  endtask
  task t_ro;
    begin
      snd(16'hFA00, 16);
      chk(rx, {1'b0, 3'h3, 3'h3, cfg[45 +: 9]});
      chk(cw, 16'h3600);
      $display("readonly done");
    end
  endtask
  task t_fifo;
    begin
      @(negedge clk) ctrlReady = 1'b0;
      for (i = 0; i < 33; i = i + 1) begin
        snd({i[0], 3'h3, 3'h1, i[8:0]}, 16);
        if (i == 0)
          chk(rx, rsp(3'h3, 3'h5));
      end
      chk(spiFail, 1'b1);
      chk(cw, 16'hB21F);
      chk(irqSeen[15:0], 16'h0002);
      for (i = 0; i < 32; i = i + 1) begin
        repeat (3) @(negedge clk);
        chk(ctrlValid, 1'b1);
        chk(ctrlData, {i[0], 3'h3, 3'h1, i[8:0]});
        ctrlReady = 1'b1;
        @(negedge clk) ctrlReady = 1'b0;
      end
      repeat (3) @(negedge clk);
      chk(ctrlValid, 1'b0);
      ctrlReady = 1'b1;
      clr;
      $display("fifo done");
    end
  endtask
  task t_modes;
    begin
      snd(16'h6000, 16);
      chk(modeState, 3'h3);
      chk(spiFail, 1'b1);
      clr;
      snd(16'h2000, 16);
      chk(rx, last);
      chk(modeState, 3'h2);
      snd(16'hC000, 16);
      chk(modeState, 3'h2);
      chk(irqSeen[15:0], 16'h0004);
      clr;
      snd(16'h1000, 16);
      chk(modeState, 3'h1);
      @(negedge clk) swDevMode = 1'b1;
      snd(16'hE000, 16);
      chk(modeState, 3'h6);
      chk(cw, 16'hE000);
      snd(16'h3000, 16);
      snd(16'hC000, 16);
      chk(modeState, 3'h4);
      snd(16'h3000, 16);
      chk(modeState, 3'h3);
      @(negedge clk) swDevMode = 1'b0;
      $display("modes done");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    print_verdict;
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_write;
    t_count;
    t_bad;
    t_ro;
    t_fifo;
    t_modes;
    print_verdict;
  end
endmodule
